//--- inc/thc_defines.svh
`ifndef THC_DEFINES_SVH
`define THC_DEFINES_SVH
// What this block does
// - With forced idle set in message mode only flag octets 0x7E and queued bit-code sends go out; queued frames are held back.
// - When no frame and no bit-code send is waiting, flag octets are sent back to back.
// - Forced idle does nothing while the signaling type select is 0 (bit-code signaling).
// - With check append set, a frame check sequence follows the last byte of each frame; with it clear, none.
// - Check append is ignored in bit-code signaling.
// - Signaling type select 0 sends a bit-code message, 1 sends message-oriented frames.
// - The written buffer pick chooses which buffer (0 or 1) is read out and sent.
// - Reading the buffer pick returns the next free buffer, 0 for 0x0600 and 1 for 0x0700.
// - While only one buffer still holds an unsent message, the read value points at the other buffer.
// - In bit-code signaling the count gives the repeats, after which the done interrupt rises and sending stops.
// - A bit-code count of zero repeats the message until another send is queued.
// - In message mode the count is the frame length in octets, header included, check octets excluded.
// - Unless auto abort off is set, leaving a running frame for bit-code signaling sends 0 then seven 1s.

// Register byte addresses
`define THC_OFF_CTRL        12'h150
`define THC_OFF_LEN         12'h154
`define THC_OFF_STS         12'h158
`define THC_OFF_MASK        12'h15C
`define THC_BUF_REGION      3'h3
`define THC_BUF_WORDS       5'h18

// Field positions
`define THC_CTRL_SIG_TYPE   0
`define THC_CTRL_CHK_APPEND 1
`define THC_CTRL_FORCE_IDLE 2
`define THC_CTRL_ABORT_OFF  6
`define THC_CTRL_WMASK      8'h47
`define THC_LEN_PICK        7
`define THC_STS_DONE        0
`define THC_STS_ABORT       1

// Reset values
`define THC_CTRL_RST        8'h00
`define THC_LEN_RST         7'h00
`define THC_MASK_RST        2'h0

// Line patterns
`define THC_FLAG            8'h7E
`define THC_ABORT_SEQ       8'hFE
`define THC_CRC_INIT        16'hFFFF
`define THC_CRC_POLY        16'h8408

// Timing
`define THC_CLK_PERIOD_NS   50
`define THC_BIT_PERIOD_NS   250
`endif

//--- inc/thc_pkg.sv
package thc_pkg;
   typedef enum logic [2:0] {SEND_FLAG, SEND_DATA, SEND_CHECK, SEND_ABORT, SEND_BITCODE} thc_send_t;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [6:0]  lenReg;
      logic        pickWr;
      logic        active;
      logic        actBuf;
      logic        actMsg;
      logic [6:0]  actLen;
      logic        pend;
      logic        pendBuf;
      logic        pendMsg;
      logic [6:0]  pendLen;
      thc_send_t   st;
      logic [7:0]  shreg;
      logic [2:0]  bitCnt;
      logic [2:0]  ones;
      logic        stuffNext;
      logic [6:0]  byteIdx;
      logic [15:0] crc;
      logic        crcHi;
      logic [6:0]  rep;
      logic [1:0]  sts;
      logic [1:0]  mask;
      logic        irq;
      logic        dlBit;
      logic        dlStrobe;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } thc_state_t;
endpackage

//--- core/thc_crc16.sv
`timescale 1ns/10ps
`include "thc_defines.svh"
module thc_crc16 (
   // Running check and next line bit
   input  wire logic [15:0] crcIn,
   input  wire logic        bitIn,
   // Check after this bit
   output logic      [15:0] crcOut
);
   always_comb begin
      crcOut = {1'b0, crcIn[15:1]};
      if (crcIn[0] ^ bitIn) begin
         crcOut = crcOut ^ `THC_CRC_POLY;
      end
   end
endmodule

//--- core/thc_tick_div.sv
`timescale 1ns/10ps
module thc_tick_div #(
   parameter int DIV = 5
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic nrst,
   // One-cycle bit enable
   output logic      tick
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

   logic [CW-1:0] cnt;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (cnt == CW'(DIV - 1)) begin
         cnt <= '0;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule

//--- core/thc_tx_link.sv
`timescale 1ns/10ps
`include "thc_defines.svh"
module thc_tx_link #(
   parameter int BIT_PERIOD_NS = `THC_BIT_PERIOD_NS
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Data link channel
   output logic             dlBit,
   output logic             dlBitStrobe,
   // Interrupt
   output logic             irqOut
);
   localparam int BIT_CYCLES_RAW = (BIT_PERIOD_NS + `THC_CLK_PERIOD_NS - 1) / `THC_CLK_PERIOD_NS;
   localparam int BIT_CYCLES     = (BIT_CYCLES_RAW < 1) ? 1 : BIT_CYCLES_RAW;

   thc_pkg::thc_state_t s;
   thc_pkg::thc_state_t next_s;

   // Two 96-byte buffers, four bytes a word; words 24..31 are never written
   logic [31:0] mem [0:63];

   logic        tick;
   logic [15:0] crcNext;
   logic        setup;
   logic        wrEn;
   logic        memHit;
   logic        busy0;
   logic        busy1;
   logic        pickRead;
   logic        finish;
   logic        killAbort;
   logic        killQuiet;
   logic        inFrame;
   logic        idleOn;

   thc_tick_div #(.DIV(BIT_CYCLES)) u_div (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .tick    (tick)
   );

   thc_crc16 u_crc (
      .crcIn  (s.crc),
      .bitIn  (s.shreg[0]),
      .crcOut (crcNext)
   );

   function automatic logic [7:0] memByte(input logic bufSel, input logic [6:0] idx);
      logic [31:0] w;
      w = mem[{bufSel, idx[6:2]}];
      return w[{idx[1:0], 3'b000} +: 8];
   endfunction

   assign setup   = psel && !penable;
   assign wrEn    = psel && penable && s.pready && pwrite;
   assign memHit  = (paddr[11:9] == `THC_BUF_REGION) && !paddr[7] && (paddr[6:2] < `THC_BUF_WORDS);
   assign busy0   = (s.active && !s.actBuf) || (s.pend && !s.pendBuf);
   assign busy1   = (s.active && s.actBuf) || (s.pend && s.pendBuf);
   assign inFrame = (s.st == thc_pkg::SEND_DATA) || (s.st == thc_pkg::SEND_CHECK);
   assign idleOn  = s.ctrl[`THC_CTRL_FORCE_IDLE] && s.ctrl[`THC_CTRL_SIG_TYPE];

   // Next free buffer; with both free, the one not picked last
   always_comb begin
      if (busy0 && !busy1) begin
         pickRead = 1'b1;
      end else if (busy1 && !busy0) begin
         pickRead = 1'b0;
      end else begin
         pickRead = !s.pickWr;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (wrEn && memHit) begin
         mem[{paddr[8], paddr[6:2]}] <= pwdata;
      end
   end

   always_comb begin
      next_s = s;
      next_s.dlStrobe = 1'b0;
      finish = 1'b0;
      killAbort = 1'b0;
      killQuiet = 1'b0;

      // Bit engine, one line bit per tick
      if (tick) begin
         next_s.dlStrobe = 1'b1;
         if (s.stuffNext) begin
            next_s.dlBit = 1'b0;
            next_s.stuffNext = 1'b0;
            next_s.ones = 3'h0;
         end else begin
            next_s.dlBit = s.shreg[0];
            next_s.shreg = {1'b0, s.shreg[7:1]};
            next_s.bitCnt = s.bitCnt + 3'h1;
            if (inFrame && s.shreg[0]) begin
               next_s.ones = s.ones + 3'h1;
               if (s.ones == 3'h4) begin
                  next_s.stuffNext = 1'b1;
                  next_s.ones = 3'h0;
               end
            end else begin
               next_s.ones = 3'h0;
            end
            if (s.st == thc_pkg::SEND_DATA) begin
               next_s.crc = crcNext;
            end
            if (s.bitCnt == 3'h7) begin
               unique case (s.st)
                  thc_pkg::SEND_FLAG, thc_pkg::SEND_ABORT: begin
                     next_s.st = thc_pkg::SEND_FLAG;
                     next_s.shreg = `THC_FLAG;
                     if (s.active && s.actMsg && !idleOn) begin
                        if (s.actLen == 7'h00) begin
                           finish = 1'b1;
                        end else begin
                           next_s.st = thc_pkg::SEND_DATA;
                           next_s.shreg = memByte(s.actBuf, 7'h00);
                           next_s.byteIdx = 7'h01;
                           next_s.crc = `THC_CRC_INIT;
                        end
                     end else if (s.active && !s.actMsg) begin
                        next_s.st = thc_pkg::SEND_BITCODE;
                        next_s.shreg = memByte(s.actBuf, 7'h00);
                        next_s.byteIdx = 7'h01;
                        next_s.rep = 7'h00;
                     end
                  end
                  thc_pkg::SEND_DATA: begin
                     if (s.byteIdx == s.actLen) begin
                        if (s.ctrl[`THC_CTRL_CHK_APPEND]) begin
                           next_s.st = thc_pkg::SEND_CHECK;
                           next_s.shreg = ~crcNext[7:0];
                           next_s.crcHi = 1'b1;
                        end else begin
                           finish = 1'b1;
                        end
                     end else begin
                        next_s.shreg = memByte(s.actBuf, s.byteIdx);
                        next_s.byteIdx = s.byteIdx + 7'h01;
                     end
                  end
                  thc_pkg::SEND_CHECK: begin
                     if (s.crcHi) begin
                        next_s.shreg = ~s.crc[15:8];
                        next_s.crcHi = 1'b0;
                     end else begin
                        finish = 1'b1;
                     end
                  end
                  thc_pkg::SEND_BITCODE: begin
                     if (s.byteIdx == 7'h01) begin
                        next_s.shreg = memByte(s.actBuf, 7'h01);
                        next_s.byteIdx = 7'h02;
                     end else begin
                        next_s.rep = s.rep + 7'h01;
                        if ((s.actLen != 7'h00 && s.rep + 7'h01 == s.actLen) ||
                            (s.actLen == 7'h00 && s.pend)) begin
                           finish = 1'b1;
                        end else begin
                           next_s.shreg = memByte(s.actBuf, 7'h00);
                           next_s.byteIdx = 7'h01;
                        end
                     end
                  end
               endcase
            end
         end
      end

      // End of transfer: closing flag, raise done, pull in the queued one
      if (finish) begin
         next_s.st = thc_pkg::SEND_FLAG;
         next_s.shreg = `THC_FLAG;
         next_s.sts[`THC_STS_DONE] = 1'b1;
      end

      // Abrupt leave of a running frame, via a control write
      if (wrEn && paddr == `THC_OFF_CTRL && s.active && s.actMsg && inFrame) begin
         if (!pwdata[`THC_CTRL_SIG_TYPE] && !pwdata[`THC_CTRL_ABORT_OFF]) begin
            killAbort = 1'b1;
         end else if (!pwdata[`THC_CTRL_SIG_TYPE] || pwdata[`THC_CTRL_FORCE_IDLE]) begin
            killQuiet = 1'b1;
         end
      end
      if (killAbort) begin
         next_s.st = thc_pkg::SEND_ABORT;
         next_s.shreg = `THC_ABORT_SEQ;
         next_s.bitCnt = 3'h0;
         next_s.stuffNext = 1'b0;
         next_s.ones = 3'h0;
         next_s.sts[`THC_STS_ABORT] = 1'b1;
      end else if (killQuiet) begin
         next_s.st = thc_pkg::SEND_FLAG;
         next_s.shreg = `THC_FLAG;
         next_s.bitCnt = 3'h0;
         next_s.stuffNext = 1'b0;
         next_s.ones = 3'h0;
      end
      if (finish || killAbort || killQuiet) begin
         next_s.active = s.pend;
         next_s.actBuf = s.pendBuf;
         next_s.actMsg = s.pendMsg;
         next_s.actLen = s.pendLen;
         next_s.pend = 1'b0;
      end

      // Register writes take effect at the access edge
      if (wrEn) begin
         unique case (paddr)
            `THC_OFF_CTRL: begin
               next_s.ctrl = pwdata[7:0] & `THC_CTRL_WMASK;
            end
            `THC_OFF_LEN: begin
               // Mode is taken now: a bit-code send needs a 0 written first
               next_s.lenReg = pwdata[6:0];
               next_s.pickWr = pwdata[`THC_LEN_PICK];
               if (!next_s.active) begin
                  next_s.active = 1'b1;
                  next_s.actBuf = pwdata[`THC_LEN_PICK];
                  next_s.actMsg = s.ctrl[`THC_CTRL_SIG_TYPE];
                  next_s.actLen = pwdata[6:0];
               end else if (!next_s.pend) begin
                  next_s.pend = 1'b1;
                  next_s.pendBuf = pwdata[`THC_LEN_PICK];
                  next_s.pendMsg = s.ctrl[`THC_CTRL_SIG_TYPE];
                  next_s.pendLen = pwdata[6:0];
               end
            end
            `THC_OFF_STS: begin
               // Set from this cycle's events wins over the clear
               next_s.sts = s.sts & ~pwdata[1:0];
               next_s.sts[`THC_STS_DONE] = next_s.sts[`THC_STS_DONE] | finish;
               next_s.sts[`THC_STS_ABORT] = next_s.sts[`THC_STS_ABORT] | killAbort;
            end
            `THC_OFF_MASK: begin
               next_s.mask = pwdata[1:0];
            end
            default: begin
            end
         endcase
      end

      // Read data is caught in the setup cycle, so access completes at once
      next_s.pready = setup;
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h0000_0000;
      if (setup) begin
         unique case (paddr)
            `THC_OFF_CTRL: next_s.prdata = {24'h00_0000, s.ctrl};
            `THC_OFF_LEN:  next_s.prdata = {24'h00_0000, pickRead, s.lenReg};
            `THC_OFF_STS:  next_s.prdata = {30'h0000_0000, s.sts};
            `THC_OFF_MASK: next_s.prdata = {30'h0000_0000, s.mask};
            default: begin
               if (memHit) begin
                  next_s.prdata = mem[{paddr[8], paddr[6:2]}];
               end else begin
                  next_s.pslverr = 1'b1;
               end
            end
         endcase
      end

      next_s.irq = |(next_s.sts & next_s.mask);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
         s.ctrl <= `THC_CTRL_RST;
         s.lenReg <= `THC_LEN_RST;
         s.mask <= `THC_MASK_RST;
         s.shreg <= `THC_FLAG;
         s.pickWr <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign prdata      = s.prdata;
   assign pready      = s.pready;
   assign pslverr     = s.pslverr;
   assign dlBit       = s.dlBit;
   assign dlBitStrobe = s.dlStrobe;
   assign irqOut      = s.irq;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   idle_blocks_frame_a: assert property (inFrame |-> !idleOn)
      else $error("frame running under forced idle");
   flag_fill_a: assert property (s.st == thc_pkg::SEND_FLAG && tick && !s.active && s.bitCnt == 3'h7
      |=> s.st == thc_pkg::SEND_FLAG && s.shreg == `THC_FLAG)
      else $error("no flag between frames");
   idle_ignored_a: assert property (s.st == thc_pkg::SEND_FLAG && tick && s.bitCnt == 3'h7 && s.active
      && !s.actMsg && s.ctrl[`THC_CTRL_FORCE_IDLE] && !wrEn |=> s.st == thc_pkg::SEND_BITCODE)
      else $error("forced idle blocked bit-code send");
   check_append_a: assert property (s.st == thc_pkg::SEND_DATA && tick && !s.stuffNext && s.bitCnt == 3'h7
      && s.byteIdx == s.actLen && !wrEn |=> (s.st == thc_pkg::SEND_CHECK) == $past(s.ctrl[1]))
      else $error("check octets wrongly appended or missing");
   check_msg_only_a: assert property (s.st == thc_pkg::SEND_CHECK |-> s.actMsg)
      else $error("check octets in bit-code send");
   mode_select_a: assert property ((s.st == thc_pkg::SEND_BITCODE |-> !s.actMsg)
      and (s.st == thc_pkg::SEND_DATA |-> s.actMsg))
      else $error("send kind does not match mode");
   buf_pick_a: assert property (wrEn && paddr == `THC_OFF_LEN && !s.active
      |=> s.active && s.actBuf == $past(pwdata[7]))
      else $error("picked buffer not taken");
   free_pick_a: assert property (setup && paddr == `THC_OFF_LEN && busy0 != busy1
      |=> prdata[7] == $past(busy0))
      else $error("read pick points at busy buffer");
   both_free_a: assert property (setup && paddr == `THC_OFF_LEN && !busy0 && !busy1
      |=> prdata[7] == !$past(s.pickWr))
      else $error("read pick wrong with both free");
   repeat_bound_a: assert property (s.st == thc_pkg::SEND_BITCODE |-> (s.actLen == 7'h00 || s.rep < s.actLen))
      else $error("bit-code repeats overran count");
   endless_repeat_a: assert property (s.st == thc_pkg::SEND_BITCODE && s.actLen == 7'h00 && !s.pend && !wrEn
      |=> s.st == thc_pkg::SEND_BITCODE)
      else $error("endless bit-code send stopped");
   frame_length_a: assert property (s.st == thc_pkg::SEND_DATA |-> s.byteIdx != 7'h00 && s.byteIdx <= s.actLen)
      else $error("frame byte index out of length");
   abort_emit_a: assert property (killAbort |=> s.st == thc_pkg::SEND_ABORT && s.shreg == `THC_ABORT_SEQ
      && s.sts[1])
      else $error("abort not sent on abrupt leave");
   zero_insert_a: assert property (tick && s.stuffNext |=> dlBitStrobe && !dlBit)
      else $error("zero not inserted after five ones");

   frame_check_c: cover property (s.st == thc_pkg::SEND_CHECK && finish);
   bitcode_done_c: cover property (s.st == thc_pkg::SEND_BITCODE && finish);
   abort_c: cover property (killAbort);
   stuff_c: cover property (s.stuffNext && s.st == thc_pkg::SEND_CHECK);
endmodule

//--- verif/thc_link_rx.sv
`timescale 1ns/10ps
module thc_link_rx (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   // Data link channel
   input  wire logic       dlBit,
   input  wire logic       dlBitStrobe,
   // Decoded traffic
   output int              flagCnt,
   output int              frameCnt,
   output int              abortCnt,
   output int              frmLen,
   output logic [7:0]      frm [0:63]
);
   int         ones;
   int         nb;
   logic       synced;
   logic [7:0] sh;
   logic [7:0] cur [0:63];

   task automatic put(input logic b);
      sh = {b, sh[7:1]};
      nb++;
      if (nb % 8 == 0 && nb <= 512)
         cur[nb / 8 - 1] = sh;
   endtask

   // Bits are only committed at a zero, so a flag's ones never reach the data
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         flagCnt = 0;
         frameCnt = 0;
         abortCnt = 0;
         frmLen = 0;
         ones = 0;
         nb = 0;
         synced = 0;
      end else if (dlBitStrobe) begin
         if (dlBit) begin
            ones++;
            if (ones == 7) begin
               abortCnt++;
               synced = 0;
               nb = 0;
            end
         end else begin
            if (ones == 6) begin
               flagCnt++;
               // Leading zero of the flag was taken as data
               if (synced && nb > 1 && (nb - 1) % 8 == 0) begin
                  frameCnt++;
                  frmLen = (nb - 1) / 8;
                  frm = cur;
               end
               synced = 1;
               nb = 0;
            end else if (ones < 6) begin
               repeat (ones) put(1'b1);
               if (ones != 5)
                  put(1'b0);
            end
            ones = 0;
         end
      end
   end
endmodule

//--- verif/tb_tx_datalink_hdlc_ctrl.sv
`timescale 1ns/10ps
`include "thc_defines.svh"
module tb_tx_datalink_hdlc_ctrl;
   logic        clk_sys = 1'b0;
   logic        nrst    = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        er;
   logic        dlBit;
   logic        dlBitStrobe;
   logic        irqOut;
   int          miscompares = 0;
   int          checkCount  = 0;
   int          flagCnt;
   int          frameCnt;
   int          abortCnt;
   int          frmLen;
   int          n0;
   logic [7:0]  rxFrm [0:63];
   logic [7:0]  msg [0:63];

   always #25 clk_sys = ~clk_sys;

   thc_tx_link #(.BIT_PERIOD_NS(50)) u_thc_tx_link (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dlBit(dlBit), .dlBitStrobe(dlBitStrobe), .irqOut(irqOut));
   thc_link_rx u_thc_link_rx (.clk_sys(clk_sys), .nrst(nrst), .dlBit(dlBit), .dlBitStrobe(dlBitStrobe),
      .flagCnt(flagCnt), .frameCnt(frameCnt), .abortCnt(abortCnt), .frmLen(frmLen), .frm(rxFrm));

   task automatic endSim;
      $display("checks %0d mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checkCount++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int   t;
      logic ok;
      t = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         ok = pready;
         t++;
      end while (ok !== 1'b1 && t < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (ok !== 1'b1) begin
         chk("pready", 32'h1, 32'h0);
         endSim();
      end
   endtask

   task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   // Byte n of the message sits in word n/4, lowest byte first
   task automatic load(input logic b, input int len);
      for (int i = 0; i < len; i += 4)
         apb(1'b1, (b ? 12'h700 : 12'h600) + 12'(i), {msg[i+3], msg[i+2], msg[i+1], msg[i]});
   endtask

   task automatic waitFrames(input int n);
      int t;
      for (t = 0; t < 4000 && frameCnt < n; t++)
         @(negedge clk_sys);
      if (frameCnt < n) begin
         chk("frame wait", 32'h1, 32'h0);
         endSim();
      end
   endtask

   task automatic waitSts(input logic [31:0] m);
      int t;
      for (t = 0; t < 300; t++) begin
         apb(1'b0, `THC_OFF_STS, 32'h0);
         if ((rd & m) != 0)
            break;
      end
      if (t == 300) begin
         chk("status wait", m, rd);
         endSim();
      end
   endtask

   function automatic logic [15:0] fcs(input int len);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = 0; i < len; i++)
         for (int k = 0; k < 8; k++)
            c = (c[0] ^ msg[i][k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
      return ~c;
   endfunction

   task automatic frmchk(input int len, input logic crc);
      chk("frame length", crc ? len + 2 : len, frmLen);
      for (int i = 0; i < len; i++)
         chk("frame byte", 32'(msg[i]), 32'(rxFrm[i]));
      if (crc)
         chk("check octets", 32'(fcs(len)), {16'h0, rxFrm[len+1], rxFrm[len]});
   endtask

   initial begin
      for (int i = 0; i < 64; i++)
         msg[i] = 8'(i * 53 + 17);
      msg[1] = 8'hFF;
      msg[2] = 8'h7E;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      rdchk("control", `THC_OFF_CTRL, 32'h0);
      rdchk("length", `THC_OFF_LEN, 32'h0);
      rdchk("status", `THC_OFF_STS, 32'h0);
      rdchk("mask", `THC_OFF_MASK, 32'h0);
      rdchk("unmapped", 12'h160, 32'h0);
      chk("slave error", 32'h1, 32'(er));
      repeat (100) @(negedge clk_sys);
      chk("idle flags", 32'h1, 32'(flagCnt >= 12));
      chk("idle frames", 32'h0, frameCnt);
      $display("test reset and idle done");
      // Frame with check octets and stuffing
      apb(1'b1, `THC_OFF_MASK, 32'h3);
      apb(1'b1, `THC_OFF_CTRL, 32'h03);
      load(1'b0, 5);
      apb(1'b1, `THC_OFF_LEN, 32'h05);
      apb(1'b0, `THC_OFF_LEN, 32'h0);
      chk("next free", 32'h1, 32'(rd[7]));
      waitFrames(1);
      frmchk(5, 1'b1);
      rdchk("done status", `THC_OFF_STS, 32'h1);
      chk("irq raised", 32'h1, 32'(irqOut));
      apb(1'b1, `THC_OFF_STS, 32'h1);
      rdchk("status cleared", `THC_OFF_STS, 32'h0);
      chk("irq cleared", 32'h0, 32'(irqOut));
      $display("test check frame done");
      // Plain frame from buffer one, interrupt masked
      apb(1'b1, `THC_OFF_MASK, 32'h0);
      apb(1'b1, `THC_OFF_CTRL, 32'h01);
      load(1'b1, 3);
      apb(1'b1, `THC_OFF_LEN, 32'h83);
      waitFrames(2);
      frmchk(3, 1'b0);
      rdchk("done status", `THC_OFF_STS, 32'h1);
      chk("irq masked", 32'h0, 32'(irqOut));
      apb(1'b1, `THC_OFF_STS, 32'h1);
      $display("test plain frame done");
      // Forced idle holds the frame back
      apb(1'b1, `THC_OFF_CTRL, 32'h05);
      load(1'b0, 4);
      n0 = flagCnt;
      apb(1'b1, `THC_OFF_LEN, 32'h04);
      repeat (300) @(negedge clk_sys);
      chk("idle held frame", 32'h2, frameCnt);
      chk("idle flags", 32'h1, 32'(flagCnt >= n0 + 35));
      rdchk("idle status", `THC_OFF_STS, 32'h0);
      apb(1'b1, `THC_OFF_CTRL, 32'h01);
      waitFrames(3);
      frmchk(4, 1'b0);
      apb(1'b1, `THC_OFF_STS, 32'h1);
      apb(1'b1, `THC_OFF_LEN, 32'h00);
      waitSts(32'h1);
      chk("empty frame", 32'h3, frameCnt);
      apb(1'b1, `THC_OFF_STS, 32'h1);
      $display("test forced idle done");
      // Bit code, three repeats; idle and check bits ignored
      msg[0] = 8'h12;
      msg[1] = 8'h34;
      for (int i = 2; i < 6; i++)
         msg[i] = msg[i-2];
      load(1'b0, 2);
      load(1'b1, 2);
      apb(1'b1, `THC_OFF_CTRL, 32'h06);
      apb(1'b1, `THC_OFF_LEN, 32'h03);
      waitFrames(4);
      frmchk(6, 1'b0);
      rdchk("repeat done", `THC_OFF_STS, 32'h1);
      apb(1'b1, `THC_OFF_STS, 32'h1);
      n0 = flagCnt;
      repeat (100) @(negedge clk_sys);
      chk("flags resume", 32'h1, 32'(flagCnt >= n0 + 11));
      $display("test bit code done");
      // Endless bit code, ended by a queued frame
      apb(1'b1, `THC_OFF_CTRL, 32'h00);
      apb(1'b1, `THC_OFF_LEN, 32'h80);
      repeat (20) @(negedge clk_sys);
      n0 = flagCnt;
      repeat (400) @(negedge clk_sys);
      chk("endless repeat", n0, flagCnt);
      rdchk("no done", `THC_OFF_STS, 32'h0);
      apb(1'b1, `THC_OFF_CTRL, 32'h01);
      msg[2] = 8'hC3;
      load(1'b0, 3);
      apb(1'b1, `THC_OFF_LEN, 32'h03);
      waitSts(32'h1);
      // Endless code shows up as one long pseudo-frame before the queued one
      waitFrames(6);
      frmchk(3, 1'b0);
      apb(1'b1, `THC_OFF_STS, 32'h1);
      $display("test endless done");
      // Abort on switch to bit code, then with abort off
      for (int i = 0; i < 40; i++)
         msg[i] = 8'(i * 29 + 3);
      load(1'b1, 40);
      n0 = abortCnt;
      apb(1'b1, `THC_OFF_LEN, 32'hA8);
      repeat (100) @(negedge clk_sys);
      apb(1'b1, `THC_OFF_CTRL, 32'h00);
      repeat (30) @(negedge clk_sys);
      chk("abort sent", n0 + 1, abortCnt);
      rdchk("abort status", `THC_OFF_STS, 32'h2);
      apb(1'b1, `THC_OFF_STS, 32'h3);
      apb(1'b1, `THC_OFF_CTRL, 32'h41);
      n0 = abortCnt;
      apb(1'b1, `THC_OFF_LEN, 32'hA8);
      repeat (100) @(negedge clk_sys);
      apb(1'b1, `THC_OFF_CTRL, 32'h40);
      repeat (30) @(negedge clk_sys);
      chk("abort off", n0, abortCnt);
      rdchk("abort off status", `THC_OFF_STS, 32'h0);
      apb(1'b1, `THC_OFF_CTRL, 32'h01);
      apb(1'b1, `THC_OFF_LEN, 32'hA8);
      repeat (100) @(negedge clk_sys);
      apb(1'b1, `THC_OFF_CTRL, 32'h05);
      repeat (30) @(negedge clk_sys);
      chk("idle cut", n0, abortCnt);
      rdchk("idle cut status", `THC_OFF_STS, 32'h0);
      $display("test abort done");
      endSim();
   end
endmodule
